// *** core/csr_pkg.sv ***
// Constants and types shared by the channel sample reducer
package csr_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int BASE_PERIOD_PS = 2500000;
    localparam int BASE_CYCLES = (BASE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] BASE_LAST = 8'(BASE_CYCLES - 1);
    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int DW = 16;
    localparam int AW = 32;
    localparam int TW = 16;
    localparam int N_CH = 14;
    localparam int N_EXT = 8;
    localparam int N_GRP = 8;
    // ----------------------------------------------------------------
    // Source indices
    // ----------------------------------------------------------------
    localparam logic [3:0] SRC_FIRST_ANALOG = 4'h0;
    localparam int HIGH_FREQ_INPUT_IDX = 4;
    localparam logic [3:0] SRC_LOCKIN_AMP = 4'h8;
    localparam logic [3:0] SRC_LOCKIN_PHASE = 4'h9;
    localparam logic [3:0] SRC_HEIGHT_CTRL = 4'ha;
    // ----------------------------------------------------------------
    // Data groups
    // ----------------------------------------------------------------
    localparam logic [2:0] GRP_SCAN = 3'h0;
    localparam logic [2:0] GRP_PASS2 = 3'h1;
    localparam logic [2:0] GRP_SPEC = 3'h2;
    localparam logic [2:0] GRP_RESON = 3'h3;
    localparam logic [2:0] GRP_SOFT = 3'h4;
    localparam logic [2:0] GRP_STEP = 3'h5;
    localparam logic [2:0] GRP_LINE = 3'h6;
    localparam logic [2:0] GRP_FFT = 3'h7;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [N_CH-1:0] AVG_EN_RST = 14'h3fff;
    localparam logic [3:0] CH_NONE = 4'hf;

    typedef enum logic [1:0] {
        ST_SEEK = 2'b00,
        ST_EMIT = 2'b01
    } csr_emit_e;
endpackage

// *** core/csr_reducer.sv ***
// Channel sample reducer: base-rate sampling, per-channel averaging or decimation, serial output
`timescale 1ns/1ps
module csr_reducer (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [csr_pkg::N_EXT*csr_pkg::DW-1:0] i_EXT_IN,
    input wire logic [csr_pkg::DW-1:0] i_LOCKIN_AMPLITUDE,
    input wire logic [csr_pkg::DW-1:0] i_LOCKIN_PHASE,
    input wire logic [csr_pkg::DW-1:0] i_HEIGHT_CTRL,
    input wire logic [csr_pkg::N_CH-1:0] i_CH_ENABLE,
    input wire logic [csr_pkg::N_CH*4-1:0] i_CH_SOURCE,
    input wire logic [csr_pkg::N_CH*3-1:0] i_CH_GROUP,
    input wire logic [csr_pkg::N_CH*csr_pkg::TW-1:0] i_CH_STIME,
    input wire logic [csr_pkg::N_GRP*csr_pkg::TW-1:0] i_GROUP_STIME,
    input wire logic [csr_pkg::TW-1:0] i_SCAN_SPEED,
    input wire logic [csr_pkg::N_CH-1:0] i_AVG_EN,
    input wire logic i_CFG_LOAD,
    output logic [csr_pkg::DW-1:0] o_LEVER_SIGNAL,
    output logic o_VALID,
    output logic [3:0] o_CH,
    output logic [csr_pkg::DW-1:0] o_DATA,
    output logic [csr_pkg::TW-1:0] o_POS,
    output logic [31:0] o_STAMP
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] base_cnt;
        logic tick;
        logic [31:0] stamp;
        logic [csr_pkg::N_CH-1:0] avg_en;
        logic [csr_pkg::N_CH-1:0][csr_pkg::AW-1:0] acc;
        logic [csr_pkg::N_CH-1:0][csr_pkg::TW-1:0] cnt;
        logic [csr_pkg::N_CH-1:0][csr_pkg::DW-1:0] first;
        logic [csr_pkg::N_CH-1:0][csr_pkg::TW-1:0] elapsed;
        logic [csr_pkg::N_CH-1:0][csr_pkg::TW-1:0] pt;
        logic [csr_pkg::N_CH-1:0][csr_pkg::AW-1:0] rsum;
        logic [csr_pkg::N_CH-1:0][csr_pkg::TW-1:0] rcnt;
        logic [csr_pkg::N_CH-1:0] pend;
        csr_pkg::csr_emit_e st;
        logic [csr_pkg::DW-1:0] lever;
        logic valid;
        logic [3:0] ch;
        logic [csr_pkg::DW-1:0] data;
        logic [csr_pkg::TW-1:0] pos;
        logic [31:0] ostamp;
    } csr_state_s;

    csr_state_s st_ff;
    csr_state_s nxt_st;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Source mux: external inputs and internal signals
    function automatic logic [csr_pkg::DW-1:0] src_value(input logic [3:0] sel);
        logic [csr_pkg::DW-1:0] v;
        v = '0;
        if (sel < 4'(csr_pkg::N_EXT)) begin
            v = i_EXT_IN[sel[2:0]*csr_pkg::DW +: csr_pkg::DW];
        end else if (sel == csr_pkg::SRC_LOCKIN_AMP) begin
            v = i_LOCKIN_AMPLITUDE;
        end else if (sel == csr_pkg::SRC_LOCKIN_PHASE) begin
            v = i_LOCKIN_PHASE;
        end else if (sel == csr_pkg::SRC_HEIGHT_CTRL) begin
            v = i_HEIGHT_CTRL;
        end
        return v;
    endfunction

    // Interval length in base periods for one channel
    function automatic logic [csr_pkg::TW-1:0] stime_of(input int c);
        logic [2:0] g;
        logic [csr_pkg::TW-1:0] t;
        g = i_CH_GROUP[c*3 +: 3];
        case (g)
            csr_pkg::GRP_SCAN: t = i_SCAN_SPEED;
            csr_pkg::GRP_LINE, csr_pkg::GRP_FFT: t = i_CH_STIME[c*csr_pkg::TW +: csr_pkg::TW];
            default: t = i_GROUP_STIME[g*csr_pkg::TW +: csr_pkg::TW];
        endcase
        if (t == '0) begin
            t = 16'h0001;
        end
        return t;
    endfunction

    // Lowest pending channel, or none
    function automatic logic [3:0] first_pend(input logic [csr_pkg::N_CH-1:0] p);
        logic [3:0] r;
        r = csr_pkg::CH_NONE;
        for (int i = csr_pkg::N_CH - 1; i >= 0; i--) begin
            if (p[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [3:0] sel;
        logic [csr_pkg::DW-1:0] smp;
        logic [csr_pkg::AW-1:0] acc_n;
        logic [csr_pkg::TW-1:0] cnt_n;
        logic [csr_pkg::AW-1:0] mean;
        sel = '0;
        smp = '0;
        acc_n = '0;
        cnt_n = '0;
        mean = '0;
        nxt_st = st_ff;
        // Base period timer
        nxt_st.tick = 1'b0;
        if (st_ff.base_cnt == csr_pkg::BASE_LAST) begin
            nxt_st.base_cnt = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.base_cnt = st_ff.base_cnt + 8'h01;
        end
        if (st_ff.tick) begin
            nxt_st.stamp = st_ff.stamp + 32'h00000001;
            nxt_st.lever = i_EXT_IN[csr_pkg::HIGH_FREQ_INPUT_IDX*csr_pkg::DW +: csr_pkg::DW];
        end
        // Emitter: at most one reduced value every two cycles, lowest channel first
        nxt_st.valid = 1'b0;
        case (st_ff.st)
            csr_pkg::ST_SEEK: begin
                sel = first_pend(st_ff.pend);
                if (sel != csr_pkg::CH_NONE) begin
                    mean = st_ff.rsum[sel] / {16'h0000, st_ff.rcnt[sel]};
                    nxt_st.data = mean[csr_pkg::DW-1:0];
                    nxt_st.ch = sel;
                    nxt_st.pos = st_ff.pt[sel];
                    nxt_st.ostamp = st_ff.stamp;
                    nxt_st.valid = 1'b1;
                    nxt_st.pend[sel] = 1'b0;
                    nxt_st.st = csr_pkg::ST_EMIT;
                end
            end
            csr_pkg::ST_EMIT: begin
                nxt_st.st = csr_pkg::ST_SEEK;
            end
            default: begin
                nxt_st.st = csr_pkg::ST_SEEK;
            end
        endcase
        // Configuration load restarts all intervals
        if (i_CFG_LOAD) begin
            nxt_st.avg_en = i_AVG_EN;
            for (int c = 0; c < csr_pkg::N_CH; c++) begin
                nxt_st.elapsed[c] = '0;
                nxt_st.pt[c] = '0;
            end
        end else if (st_ff.tick) begin
            // Per-channel reduction; sources may be shared freely
            for (int c = 0; c < csr_pkg::N_CH; c++) begin
                sel = i_CH_SOURCE[c*4 +: 4];
                smp = src_value(sel);
                if (st_ff.elapsed[c] == '0) begin
                    acc_n = {16'h0000, smp};
                    cnt_n = 16'h0001;
                    nxt_st.first[c] = smp;
                end else begin
                    acc_n = st_ff.acc[c] + {16'h0000, smp};
                    cnt_n = st_ff.cnt[c] + 16'h0001;
                end
                if (i_CH_ENABLE[c]) begin
                    nxt_st.acc[c] = acc_n;
                    nxt_st.cnt[c] = cnt_n;
                    if (st_ff.elapsed[c] + 16'h0001 >= stime_of(c)) begin
                        nxt_st.elapsed[c] = '0;
                        nxt_st.pt[c] = st_ff.pt[c] + 16'h0001;
                        nxt_st.pend[c] = 1'b1;
                        if (st_ff.avg_en[c]) begin
                            nxt_st.rsum[c] = acc_n;
                            nxt_st.rcnt[c] = cnt_n;
                        end else begin
                            nxt_st.rsum[c] = {16'h0000, nxt_st.first[c]};
                            nxt_st.rcnt[c] = 16'h0001;
                        end
                    end else begin
                        nxt_st.elapsed[c] = st_ff.elapsed[c] + 16'h0001;
                    end
                end else begin
                    nxt_st.elapsed[c] = '0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            st_ff <= '0;
            st_ff.avg_en <= csr_pkg::AVG_EN_RST;
            st_ff.ch <= csr_pkg::CH_NONE;
            st_ff.st <= csr_pkg::ST_SEEK;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_LEVER_SIGNAL = st_ff.lever;
    assign o_VALID = st_ff.valid;
    assign o_CH = st_ff.ch;
    assign o_DATA = st_ff.data;
    assign o_POS = st_ff.pos;
    assign o_STAMP = st_ff.ostamp;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_base_period;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        st_ff.tick |-> ##250 st_ff.tick;
    endproperty
    a_base_period: assert property (p_base_period) else $error("base tick period wrong");

    property p_no_early_tick;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        st_ff.tick |=> !st_ff.tick [*8];
    endproperty
    a_no_early_tick: assert property (p_no_early_tick) else $error("base tick too early");

    property p_avg_default;
        @(posedge I_CLK)
        I_SYS_RST |=> st_ff.avg_en == 14'h3fff;
    endproperty
    a_avg_default: assert property (p_avg_default) else $error("averaging not on after reset");

    property p_avg_count;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (st_ff.tick && !i_CFG_LOAD && i_CH_ENABLE[0] && st_ff.avg_en[0]
            && nxt_st.elapsed[0] == 16'h0000)
        |=> st_ff.rcnt[0] == stime_of(0);
    endproperty
    a_avg_count: assert property (p_avg_count) else $error("average count differs from interval");

    property p_avg_off_first;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (st_ff.tick && !i_CFG_LOAD && i_CH_ENABLE[1] && !st_ff.avg_en[1] && !st_ff.pend[1]
            && nxt_st.pend[1])
        |=> st_ff.rcnt[1] == 16'h0001 && st_ff.rsum[1] == {16'h0000, st_ff.first[1]};
    endproperty
    a_avg_off_first: assert property (p_avg_off_first) else $error("decimation not first sample");

    property p_emit_pending;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (st_ff.st == csr_pkg::ST_SEEK && st_ff.pend != '0)
        |=> o_VALID && (($past(st_ff.pend) >> o_CH) & 14'h0001) == 14'h0001;
    endproperty
    a_emit_pending: assert property (p_emit_pending) else $error("pending value not emitted");

    property p_valid_single;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        o_VALID |=> !o_VALID;
    endproperty
    a_valid_single: assert property (p_valid_single) else $error("valid longer than one cycle");

    property p_ch_range;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        o_VALID |-> o_CH < 4'he;
    endproperty
    a_ch_range: assert property (p_ch_range) else $error("channel index out of range");

    property p_lever_route;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        st_ff.tick |=> o_LEVER_SIGNAL == $past(i_EXT_IN[79:64]);
    endproperty
    a_lever_route: assert property (p_lever_route) else $error("lever signal not routed");

    property p_lever_hold;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        !st_ff.tick |=> $stable(o_LEVER_SIGNAL);
    endproperty
    a_lever_hold: assert property (p_lever_hold) else $error("lever signal changed between base ticks");

    property p_stamp_step;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        st_ff.tick |=> st_ff.stamp == $past(st_ff.stamp) + 32'h00000001;
    endproperty
    a_stamp_step: assert property (p_stamp_step) else $error("time stamp not advanced per base period");

    property p_cfg_restart;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        i_CFG_LOAD |=> st_ff.elapsed == '0 && st_ff.avg_en == $past(i_AVG_EN);
    endproperty
    a_cfg_restart: assert property (p_cfg_restart) else $error("configuration load not applied");
endmodule

// *** bench/csr_host_model.sv ***
// Host side model: collects the reduced words of every channel
`timescale 1ns/1ps
module csr_host_model (
    input wire logic i_clk,
    input wire logic i_valid,
    input wire logic [3:0] i_ch,
    input wire logic [csr_pkg::DW-1:0] i_data,
    input wire logic [csr_pkg::TW-1:0] i_pos,
    input wire logic [31:0] i_stamp
);
    int cnt [16];
    logic [csr_pkg::DW-1:0] data [16];
    logic [csr_pkg::TW-1:0] pos [16];
    logic [31:0] stamp [16];
    logic [31:0] prev_stamp [16];
    time t_last [16];
    time t_prev [16];
    initial begin
        for (int k = 0; k < 16; k++) begin
            cnt[k] = 0;
            stamp[k] = '0;
            t_last[k] = 0;
        end
    end
    // Each word is stored with its point index and time stamp
    always @(posedge i_clk) begin
        if (i_valid === 1'b1) begin
            cnt[i_ch] <= cnt[i_ch] + 1;
            data[i_ch] <= i_data;
            pos[i_ch] <= i_pos;
            prev_stamp[i_ch] <= stamp[i_ch];
            stamp[i_ch] <= i_stamp;
            t_prev[i_ch] <= t_last[i_ch];
            t_last[i_ch] <= $time;
        end
    end
endmodule

// *** bench/tb.sv ***
// Self-checking testbench of the channel sample reducer
`timescale 1ns/1ps
module tb;
    logic I_CLK = 1'b0;
    logic I_SYS_RST = 1'b1;
    logic [csr_pkg::N_EXT*csr_pkg::DW-1:0] ext = '0;
    logic [15:0] amp = 16'h0123;
    logic [15:0] phase = 16'h4567;
    logic [15:0] height = 16'h89ab;
    logic [13:0] ch_en = '0;
    logic [55:0] ch_src = '0;
    logic [41:0] ch_grp = '0;
    logic [223:0] ch_st = '0;
    logic [127:0] grp_st = '0;
    logic [15:0] scan_spd = 16'h0001;
    logic [13:0] avg_en = 14'h3fff;
    logic cfg_load = 1'b0;
    logic [15:0] lever;
    logic [15:0] data;
    logic [15:0] pos;
    logic [31:0] stamp;
    logic valid;
    logic [3:0] ch;
    int n_fail = 0;
    int tests_run = 0;
    always #5 I_CLK = ~I_CLK;
    csr_reducer csr_reducer_i (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_EXT_IN(ext), .i_LOCKIN_AMPLITUDE(amp),
        .i_LOCKIN_PHASE(phase), .i_HEIGHT_CTRL(height), .i_CH_ENABLE(ch_en), .i_CH_SOURCE(ch_src),
        .i_CH_GROUP(ch_grp), .i_CH_STIME(ch_st), .i_GROUP_STIME(grp_st), .i_SCAN_SPEED(scan_spd),
        .i_AVG_EN(avg_en), .i_CFG_LOAD(cfg_load), .o_LEVER_SIGNAL(lever), .o_VALID(valid), .o_CH(ch),
        .o_DATA(data), .o_POS(pos), .o_STAMP(stamp));
    csr_host_model csr_host_model_i (.i_clk(I_CLK), .i_valid(valid), .i_ch(ch), .i_data(data), .i_pos(pos),
        .i_stamp(stamp));
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic set_ch(input int c, input logic [3:0] src, input logic [2:0] grp, input logic [15:0] st);
        ch_en[c] <= 1'b1;
        ch_src[c*4 +: 4] <= src;
        ch_grp[c*3 +: 3] <= grp;
        ch_st[c*16 +: 16] <= st;
    endtask
    task automatic wait_word(input int c);
        int n0;
        n0 = csr_host_model_i.cnt[c];
        for (int k = 0; k < 3000 && csr_host_model_i.cnt[c] == n0; k++) begin
            @(posedge I_CLK);
            #1;
        end
        if (csr_host_model_i.cnt[c] == n0) begin
            n_fail++;
            $display("Error at %0t: no word on channel %0d", $time, c);
        end
    endtask
    // Two samples a then b fall into one interval of two base periods
    task automatic two_values(input int c, input logic [15:0] a, input logic [15:0] b);
        wait_word(c);
        repeat (125) @(posedge I_CLK);
        ext[15:0] <= a;
        repeat (250) @(posedge I_CLK);
        ext[15:0] <= b;
        wait_word(c);
    endtask
    task automatic do_reset;
        @(posedge I_CLK);
        I_SYS_RST <= 1'b1;
        ch_en <= '0;
        repeat (20) @(posedge I_CLK);
        I_SYS_RST <= 1'b0;
        @(posedge I_CLK);
        #1;
        check(valid, 1'b0);
        check(ch, 4'hf);
    endtask
    task automatic sc_default_avg;
        @(posedge I_CLK);
        set_ch(0, csr_pkg::SRC_FIRST_ANALOG, csr_pkg::GRP_LINE, 16'h0002);
        two_values(0, 16'h1000, 16'h2003);
        check(csr_host_model_i.data[0], 16'h1801);
        check(csr_host_model_i.stamp[0] - csr_host_model_i.prev_stamp[0], 32'h2);
        check(32'(csr_host_model_i.t_last[0] - csr_host_model_i.t_prev[0]), 32'd5000);
    endtask
    task automatic sc_first_sample;
        @(posedge I_CLK);
        set_ch(1, csr_pkg::SRC_FIRST_ANALOG, csr_pkg::GRP_FFT, 16'h0002);
        avg_en <= 14'h3ffd;
        cfg_load <= 1'b1;
        @(posedge I_CLK);
        cfg_load <= 1'b0;
        wait_word(0);
        check(csr_host_model_i.pos[0], 16'h0001);
        two_values(0, 16'h0040, 16'h0f00);
        repeat (4) @(posedge I_CLK);
        check(csr_host_model_i.data[0], 16'h07a0);
        check(csr_host_model_i.data[1], 16'h0040);
        check(csr_host_model_i.pos[1], 16'h0003);
    endtask
    task automatic sc_groups;
        int n0;
        @(posedge I_CLK);
        ch_en[1:0] <= 2'b00;
        set_ch(2, csr_pkg::SRC_LOCKIN_AMP, csr_pkg::GRP_SPEC, 16'h0001);
        set_ch(3, csr_pkg::SRC_HEIGHT_CTRL, csr_pkg::GRP_SPEC, 16'h0007);
        set_ch(4, 4'h4, csr_pkg::GRP_SCAN, 16'h0001);
        set_ch(13, csr_pkg::SRC_LOCKIN_PHASE, csr_pkg::GRP_FFT, 16'h0003);
        grp_st[int'(csr_pkg::GRP_SPEC)*16 +: 16] <= 16'h0003;
        scan_spd <= 16'h0004;
        ext[79:64] <= 16'h5a5a;
        wait_word(4);
        n0 = csr_host_model_i.cnt[0];
        wait_word(4);
        wait_word(13);
        check(csr_host_model_i.stamp[4] - csr_host_model_i.prev_stamp[4], 32'h4);
        check(csr_host_model_i.data[4], 16'h5a5a);
        check(lever, 16'h5a5a);
        check(csr_host_model_i.stamp[2] - csr_host_model_i.prev_stamp[2], 32'h3);
        check(csr_host_model_i.stamp[3] - csr_host_model_i.prev_stamp[3], 32'h3);
        check(csr_host_model_i.stamp[13] - csr_host_model_i.prev_stamp[13], 32'h3);
        check(csr_host_model_i.data[2], amp);
        check(csr_host_model_i.data[3], height);
        check(csr_host_model_i.data[13], phase);
        check(csr_host_model_i.cnt[0], n0);
    endtask
    task automatic sc_reset_default;
        do_reset();
        @(posedge I_CLK);
        set_ch(1, csr_pkg::SRC_FIRST_ANALOG, csr_pkg::GRP_FFT, 16'h0002);
        two_values(1, 16'h0002, 16'h0005);
        check(csr_host_model_i.data[1], 16'h0003);
    endtask
    initial begin
        do_reset();
        sc_default_avg();
        sc_first_sample();
        sc_groups();
        sc_reset_default();
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge I_CLK);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
